/* File: pkg/cpcr_pkg.sv */
/*
 Constants for the clock and power control register bank: addresses, field positions,
 reset values, write masks and timing counts.
 Assumes a 20 MHz reference clock and a 16-bit register port.
*/
// Notes on behaviour
// - Crystal start trim, smaller code faster, resets 0xAA
// - Count slow cycles after enable, then interrupt
// - DC-block filter enable from bit 0, reset set
// - Bit 1 keeps amplitude detector bias alive
// - GPIO reset polarity bit 7; pad fixed
// - 4-bit GPIO selector; 0 off, 13-15 reserved
// - Pin held time x 4096 slow cycles
// - Hold time zero disables pin reset timer
// - Bandgap refresh period in 2 ms units
// - Bit 15 selects manual or automatic rail switch
// - Manual mode: bit 2 closes the rail switch
// - Decode two-bit low regulator mode
// - Bit 3 enables core regulator retention
// - Bits 8 and 4 turn off pump, regulator
// - Bit 7 forces regulator references into hold
// - DC-DC target nominal plus signed 25 mV offset
// - Crystal regulator 0.9 V plus offset, reset 011
// - Low regulator 1.1 V plus offset, reset 7
`default_nettype none
package cpcr_pkg;
	localparam int REF_CLK_HZ = 20_000_000;
	localparam int SLOW_CLK_HZ = 32_768;
	localparam int SLOW_DIV_CYCLES = REF_CLK_HZ / SLOW_CLK_HZ;
	localparam int REFRESH_UNIT_US = 2000;
	localparam int REFRESH_UNIT_CYCLES = REF_CLK_HZ / 1_000_000 * REFRESH_UNIT_US;
	localparam int HOLD_TICKS_PER_UNIT = 4096;

	localparam logic [31:0] ADDR_START_TRIM = 32'h5000_0030;
	localparam logic [31:0] ADDR_READY_DELAY = 32'h5000_0034;
	localparam logic [31:0] ADDR_CORE_CTRL = 32'h5000_0038;
	localparam logic [31:0] ADDR_PIN_SELECT = 32'h5000_0040;
	localparam logic [31:0] ADDR_HOLD_TIME = 32'h5000_0042;
	localparam logic [31:0] ADDR_REFRESH = 32'h5000_0050;
	localparam logic [31:0] ADDR_POWER_CTRL = 32'h5000_0052;
	localparam logic [31:0] ADDR_LEVEL_TRIM = 32'h5000_0054;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'h5000_0060;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'h5000_0062;

	localparam logic [15:0] RST_START_TRIM = 16'h00aa;
	localparam logic [15:0] RST_READY_DELAY = 16'h0000;
	localparam logic [15:0] RST_CORE_CTRL = 16'h0015;
	localparam logic [15:0] RST_PIN_SELECT = 16'h0000;
	localparam logic [15:0] RST_HOLD_TIME = 16'h0018;
	localparam logic [15:0] RST_REFRESH = 16'h0080;
	localparam logic [15:0] RST_POWER_CTRL = 16'h4000;
	localparam logic [15:0] RST_LEVEL_TRIM = 16'h1a3e;

	localparam logic [15:0] WM_START_TRIM = 16'hffff;
	localparam logic [15:0] WM_READY_DELAY = 16'h00ff;
	localparam logic [15:0] WM_CORE_CTRL = 16'h00ff;
	localparam logic [15:0] WM_PIN_SELECT = 16'h00ff;
	localparam logic [15:0] WM_HOLD_TIME = 16'h007f;
	localparam logic [15:0] WM_REFRESH = 16'h0fff;
	localparam logic [15:0] WM_POWER_CTRL = 16'h93ff;
	localparam logic [15:0] WM_LEVEL_TRIM = 16'h3e7e;
	localparam logic [15:0] WM_IRQ = 16'h0003;

	localparam int START_CODE_LSB = 0;
	localparam int RAMP_CODE_LSB = 8;
	localparam int CORE_DCBLOCK_BIT = 0;
	localparam int CORE_BIAS_KEEP_BIT = 1;
	localparam int CORE_CUR_LSB = 2;
	localparam int CORE_AMPL_LSB = 5;
	localparam int PIN_SEL_LSB = 0;
	localparam int PIN_POL_BIT = 7;
	localparam logic [3:0] PIN_SEL_MAX = 4'hc;
	localparam int PWR_AUTO_BIT = 15;
	localparam int PWR_POR_HIGH_OFF_BIT = 12;
	localparam int PWR_POR_LOW_OFF_BIT = 9;
	localparam int PWR_CP_OFF_BIT = 8;
	localparam int PWR_VREF_HOLD_BIT = 7;
	localparam int PWR_LOW_MODE_LSB = 5;
	localparam int PWR_CORE_OFF_BIT = 4;
	localparam int PWR_RET_BIT = 3;
	localparam int PWR_RAIL_BIT = 2;
	localparam int PWR_CMP_OK_BIT = 1;
	localparam int PWR_CMP_NOK_BIT = 0;
	localparam int LVL_DCDC_TRIM_LSB = 11;
	localparam int LVL_DCDC_LEVEL_LSB = 9;
	localparam int LVL_XTAL_LSB = 4;
	localparam int LVL_LOW_LSB = 1;
	localparam int IRQ_READY_BIT = 0;
	localparam int IRQ_PIN_BIT = 1;

	localparam logic [11:0] STEP_MV = 12'h019;
	localparam logic [11:0] TRIM_ZERO_MV = 12'h04b;
	localparam logic [11:0] XTAL_NOM_MV = 12'h384;
	localparam logic [11:0] LOW_NOM_MV = 12'h44c;
	localparam logic [11:0] DCDC_1V1_MV = 12'h44c;
	localparam logic [11:0] DCDC_1V8_MV = 12'h708;
	localparam logic [11:0] DCDC_2V5_MV = 12'h9c4;
	localparam logic [11:0] DCDC_3V0_MV = 12'hbb8;
endpackage
`default_nettype wire

/* File: design/cpcr_regs.sv */
/*
 Clock and power control register bank with crystal-ready delay, pin reset hold timer
 and bandgap refresh scheduler.
 Assumes a synchronous register port on ref_clk_in; pad, GPIO and analog status inputs are
 asynchronous and are synchronised here.
*/
// The strobed register port was left to the implementer.
`default_nettype none
module cpcr_regs #(
	parameter int SLOW_DIV = cpcr_pkg::SLOW_DIV_CYCLES,
	parameter int HOLD_TICKS = cpcr_pkg::HOLD_TICKS_PER_UNIT,
	parameter int REFRESH_UNIT = cpcr_pkg::REFRESH_UNIT_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [31:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	input wire logic xtal_enable_in,
	input wire logic sleep_in,
	input wire logic boost_mode_in,
	input wire logic vbat_high_ok_in,
	input wire logic reset_pad_n_in,
	input wire logic [11:0] gpio_in,
	output logic irq_out,
	output logic por_request_out,
	output logic bandgap_refresh_out,
	output logic [7:0] crystal_start_code_out,
	output logic [7:0] crystal_ramp_code_out,
	output logic [2:0] core_ampl_trim_out,
	output logic [2:0] core_current_out,
	output logic amp_detector_bias_keep_out,
	output logic dcblock_enable_out,
	output logic rail_switch_closed_out,
	output logic low_regulator_on_out,
	output logic low_regulator_high_current_out,
	output logic core_regulator_retention_out,
	output logic core_regulator_off_out,
	output logic charge_pump_off_out,
	output logic reference_hold_force_out,
	output logic por_vbat_high_off_out,
	output logic por_vbat_low_off_out,
	output logic cmp_high_ok_enable_out,
	output logic cmp_high_nok_enable_out,
	output logic [11:0] dcdc_target_mv_out,
	output logic [11:0] crystal_regulator_mv_out,
	output logic [11:0] low_regulator_mv_out
);
	import cpcr_pkg::*;

	typedef struct packed {
		logic [15:0] start_trim;
		logic [15:0] ready_delay;
		logic [15:0] core_ctrl;
		logic [15:0] pin_select;
		logic [15:0] hold_time;
		logic [15:0] refresh;
		logic [15:0] power_ctrl;
		logic [15:0] level_trim;
		logic [15:0] irq_status;
		logic [15:0] irq_mask;
		logic [15:0] rdata;
		logic [14:0] sync1;
		logic [14:0] sync2;
		logic xtal_en_prev;
		logic [9:0] slow_div;
		logic slow_tick;
		logic rdy_run;
		logic [7:0] rdy_cnt;
		logic [12:0] hold_pre;
		logic [6:0] hold_units;
		logic por_req;
		logic [15:0] unit_div;
		logic [11:0] ref_units;
		logic refresh_pulse;
		logic rail_closed;
		logic low_on;
		logic low_high;
		logic [11:0] dcdc_mv;
		logic [11:0] xtal_mv;
		logic [11:0] low_mv;
		logic irq;
	} cpcr_state_t;

	cpcr_state_t state_reg;
	cpcr_state_t state_next;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [15:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	function automatic logic [11:0] trim_mv(input logic [11:0] nom, input logic [2:0] code);
		trim_mv = 12'(nom + 12'(code) * STEP_MV - TRIM_ZERO_MV);
	endfunction

	function automatic logic [11:0] dcdc_nominal(input logic [1:0] lvl);
		case (lvl)
			2'h0: dcdc_nominal = DCDC_1V1_MV;
			2'h1: dcdc_nominal = DCDC_1V8_MV;
			2'h2: dcdc_nominal = DCDC_2V5_MV;
			default: dcdc_nominal = DCDC_3V0_MV;
		endcase
	endfunction

	// Returns {on, high_current}
	function automatic logic [1:0] low_mode(input logic [1:0] mode, input logic sleep);
		case (mode)
			2'h0: low_mode = sleep ? 2'h0 : 2'h3;
			2'h1: low_mode = 2'h0;
			2'h2: low_mode = 2'h2;
			default: low_mode = sleep ? 2'h2 : 2'h3;
		endcase
	endfunction

	logic [11:0] gpio_s;
	logic pad_n_s;
	logic boost_s;
	logic vbat_ok_s;
	logic [3:0] pin_sel;
	logic gpio_level;
	logic pin_active;
	logic pin_event;
	logic ready_event;
	logic unit_tick;
	logic [15:0] clr;
	logic [1:0] lm;

	always_comb begin
		state_next = state_reg;
		gpio_s = state_reg.sync2[11:0];
		pad_n_s = state_reg.sync2[12];
		boost_s = state_reg.sync2[13];
		vbat_ok_s = state_reg.sync2[14];
		pin_sel = state_reg.pin_select[PIN_SEL_LSB +: 4];
		pin_event = 1'b0;
		ready_event = 1'b0;
		clr = 16'h0000;

		// Input synchronisers
		state_next.sync1 = {vbat_high_ok_in, boost_mode_in, reset_pad_n_in, gpio_in};
		state_next.sync2 = state_reg.sync1;

		// Register writes
		if (wr_in) begin
			case (addr_in)
				ADDR_START_TRIM: state_next.start_trim = merge(state_reg.start_trim, wdata_in, WM_START_TRIM);
				ADDR_READY_DELAY: state_next.ready_delay = merge(state_reg.ready_delay, wdata_in, WM_READY_DELAY);
				ADDR_CORE_CTRL: state_next.core_ctrl = merge(state_reg.core_ctrl, wdata_in, WM_CORE_CTRL);
				ADDR_PIN_SELECT: state_next.pin_select = merge(state_reg.pin_select, wdata_in, WM_PIN_SELECT);
				ADDR_HOLD_TIME: state_next.hold_time = merge(state_reg.hold_time, wdata_in, WM_HOLD_TIME);
				ADDR_REFRESH: state_next.refresh = merge(state_reg.refresh, wdata_in, WM_REFRESH);
				ADDR_POWER_CTRL: state_next.power_ctrl = merge(state_reg.power_ctrl, wdata_in, WM_POWER_CTRL);
				ADDR_LEVEL_TRIM: state_next.level_trim = merge(state_reg.level_trim, wdata_in, WM_LEVEL_TRIM);
				ADDR_IRQ_MASK: state_next.irq_mask = merge(state_reg.irq_mask, wdata_in, WM_IRQ);
				ADDR_IRQ_STATUS: clr = wdata_in & WM_IRQ;
				default: clr = 16'h0000;
			endcase
		end

		// Register reads, data valid only in the following cycle
		state_next.rdata = 16'h0000;
		if (rd_in) begin
			case (addr_in)
				ADDR_START_TRIM: state_next.rdata = state_reg.start_trim;
				ADDR_READY_DELAY: state_next.rdata = state_reg.ready_delay;
				ADDR_CORE_CTRL: state_next.rdata = state_reg.core_ctrl;
				ADDR_PIN_SELECT: state_next.rdata = state_reg.pin_select;
				ADDR_HOLD_TIME: state_next.rdata = state_reg.hold_time;
				ADDR_REFRESH: state_next.rdata = state_reg.refresh;
				ADDR_POWER_CTRL: state_next.rdata = state_reg.power_ctrl;
				ADDR_LEVEL_TRIM: state_next.rdata = state_reg.level_trim;
				ADDR_IRQ_STATUS: state_next.rdata = state_reg.irq_status;
				ADDR_IRQ_MASK: state_next.rdata = state_reg.irq_mask;
				default: state_next.rdata = 16'h0000;
			endcase
		end

		// Slow clock enable from reference divider
		state_next.slow_tick = 1'b0;
		if (state_reg.slow_div == 10'(SLOW_DIV - 1)) begin
			state_next.slow_div = 10'h000;
			state_next.slow_tick = 1'b1;
		end else begin
			state_next.slow_div = state_reg.slow_div + 10'h001;
		end

		// Crystal ready delay
		state_next.xtal_en_prev = xtal_enable_in;
		if (!xtal_enable_in) begin
			state_next.rdy_run = 1'b0;
		end else if (!state_reg.xtal_en_prev) begin
			state_next.rdy_cnt = state_reg.ready_delay[7:0];
			state_next.rdy_run = (state_reg.ready_delay[7:0] != 8'h00);
		end else if (state_reg.rdy_run && state_reg.slow_tick) begin
			state_next.rdy_cnt = state_reg.rdy_cnt - 8'h01;
			if (state_reg.rdy_cnt == 8'h01) begin
				state_next.rdy_run = 1'b0;
				ready_event = 1'b1;
			end
		end

		// Pin reset trigger: pad fixed active low, GPIO polarity programmable
		gpio_level = 1'b0;
		if (pin_sel != 4'h0 && pin_sel <= PIN_SEL_MAX) begin
			gpio_level = gpio_s[4'(pin_sel - 4'h1)];
		end
		pin_active = !pad_n_s;
		if (pin_sel != 4'h0 && pin_sel <= PIN_SEL_MAX) begin
			pin_active = pin_active || (gpio_level == state_reg.pin_select[PIN_POL_BIT]);
		end

		// Hold timer counts slow ticks while the trigger is held
		if (!pin_active || state_reg.hold_time[6:0] == 7'h00) begin
			state_next.hold_pre = 13'h0000;
			state_next.hold_units = 7'h00;
			state_next.por_req = 1'b0;
		end else if (!state_reg.por_req && state_reg.slow_tick) begin
			if (state_reg.hold_pre == 13'(HOLD_TICKS - 1)) begin
				state_next.hold_pre = 13'h0000;
				state_next.hold_units = state_reg.hold_units + 7'h01;
				if (state_reg.hold_units + 7'h01 == state_reg.hold_time[6:0]) begin
					state_next.por_req = 1'b1;
					pin_event = 1'b1;
				end
			end else begin
				state_next.hold_pre = state_reg.hold_pre + 13'h0001;
			end
		end

		// Bandgap refresh scheduler in 2 ms units
		unit_tick = (state_reg.unit_div == 16'(REFRESH_UNIT - 1));
		state_next.unit_div = unit_tick ? 16'h0000 : state_reg.unit_div + 16'h0001;
		state_next.refresh_pulse = 1'b0;
		if (state_reg.refresh[11:0] == 12'h000) begin
			state_next.ref_units = 12'h000;
		end else if (unit_tick) begin
			if (state_reg.ref_units + 12'h001 >= state_reg.refresh[11:0]) begin
				state_next.ref_units = 12'h000;
				state_next.refresh_pulse = 1'b1;
			end else begin
				state_next.ref_units = state_reg.ref_units + 12'h001;
			end
		end

		// Sticky status: a new event beats a clear in the same cycle
		state_next.irq_status = state_reg.irq_status & ~clr;
		if (ready_event) begin
			state_next.irq_status[IRQ_READY_BIT] = 1'b1;
		end
		if (pin_event) begin
			state_next.irq_status[IRQ_PIN_BIT] = 1'b1;
		end
		state_next.irq = |(state_next.irq_status & state_next.irq_mask);

		// Rail switch: auto closes only in boost with high rail good
		if (state_reg.power_ctrl[PWR_AUTO_BIT]) begin
			state_next.rail_closed = boost_s && vbat_ok_s;
		end else begin
			state_next.rail_closed = state_reg.power_ctrl[PWR_RAIL_BIT];
		end

		lm = low_mode(state_reg.power_ctrl[PWR_LOW_MODE_LSB +: 2], sleep_in);
		state_next.low_on = lm[1];
		state_next.low_high = lm[0];

		// Regulator targets in millivolts
		state_next.dcdc_mv = trim_mv(dcdc_nominal(state_reg.level_trim[LVL_DCDC_LEVEL_LSB +: 2]),
			state_reg.level_trim[LVL_DCDC_TRIM_LSB +: 3]);
		state_next.xtal_mv = trim_mv(XTAL_NOM_MV, state_reg.level_trim[LVL_XTAL_LSB +: 3]);
		state_next.low_mv = trim_mv(LOW_NOM_MV, state_reg.level_trim[LVL_LOW_LSB +: 3]);
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			state_reg <= '0;
			state_reg.start_trim <= RST_START_TRIM;
			state_reg.ready_delay <= RST_READY_DELAY;
			state_reg.core_ctrl <= RST_CORE_CTRL;
			state_reg.pin_select <= RST_PIN_SELECT;
			state_reg.hold_time <= RST_HOLD_TIME;
			state_reg.refresh <= RST_REFRESH;
			state_reg.power_ctrl <= RST_POWER_CTRL;
			state_reg.level_trim <= RST_LEVEL_TRIM;
			state_reg.sync1 <= 15'h1000;
			state_reg.sync2 <= 15'h1000;
			state_reg.dcdc_mv <= DCDC_1V8_MV;
			state_reg.xtal_mv <= XTAL_NOM_MV;
			state_reg.low_mv <= 12'h4b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_out = state_reg.rdata;
	assign irq_out = state_reg.irq;
	assign por_request_out = state_reg.por_req;
	assign bandgap_refresh_out = state_reg.refresh_pulse;
	assign crystal_start_code_out = state_reg.start_trim[START_CODE_LSB +: 8];
	assign crystal_ramp_code_out = state_reg.start_trim[RAMP_CODE_LSB +: 8];
	assign core_ampl_trim_out = state_reg.core_ctrl[CORE_AMPL_LSB +: 3];
	assign core_current_out = state_reg.core_ctrl[CORE_CUR_LSB +: 3];
	assign amp_detector_bias_keep_out = state_reg.core_ctrl[CORE_BIAS_KEEP_BIT];
	assign dcblock_enable_out = state_reg.core_ctrl[CORE_DCBLOCK_BIT];
	assign rail_switch_closed_out = state_reg.rail_closed;
	assign low_regulator_on_out = state_reg.low_on;
	assign low_regulator_high_current_out = state_reg.low_high;
	assign core_regulator_retention_out = state_reg.power_ctrl[PWR_RET_BIT];
	assign core_regulator_off_out = state_reg.power_ctrl[PWR_CORE_OFF_BIT];
	assign charge_pump_off_out = state_reg.power_ctrl[PWR_CP_OFF_BIT];
	assign reference_hold_force_out = state_reg.power_ctrl[PWR_VREF_HOLD_BIT];
	assign por_vbat_high_off_out = state_reg.power_ctrl[PWR_POR_HIGH_OFF_BIT];
	assign por_vbat_low_off_out = state_reg.power_ctrl[PWR_POR_LOW_OFF_BIT];
	assign cmp_high_ok_enable_out = state_reg.power_ctrl[PWR_CMP_OK_BIT];
	assign cmp_high_nok_enable_out = state_reg.power_ctrl[PWR_CMP_NOK_BIT];
	assign dcdc_target_mv_out = state_reg.dcdc_mv;
	assign crystal_regulator_mv_out = state_reg.xtal_mv;
	assign low_regulator_mv_out = state_reg.low_mv;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);

	sequence s_ready_last;
		state_reg.rdy_run && state_reg.slow_tick && state_reg.rdy_cnt == 8'h01 && xtal_enable_in;
	endsequence

	sequence s_status_clear;
		wr_in && addr_in == ADDR_IRQ_STATUS && wdata_in[IRQ_READY_BIT];
	endsequence

	// Set wins over a clear in the same cycle
	property p_ready_fires;
		s_ready_last |=> state_reg.irq_status[IRQ_READY_BIT];
	endproperty
	a_ready_fires: assert property (p_ready_fires) else $error("ready event lost");

	property p_status_clear;
		s_status_clear ##0 (!ready_event) |=> !state_reg.irq_status[IRQ_READY_BIT];
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("ready status not cleared");

	property p_ready_zero;
		(xtal_enable_in && !state_reg.xtal_en_prev && state_reg.ready_delay[7:0] == 8'h00) |=> !state_reg.rdy_run;
	endproperty
	a_ready_zero: assert property (p_ready_zero) else $error("zero count started delay");

	property p_read_data;
		(rd_in && addr_in == ADDR_LEVEL_TRIM) |=> rdata_out == $past(state_reg.level_trim)
			##1 ($past(rd_in) || rdata_out == 16'h0000);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data wrong");

	property p_reserved;
		(state_reg.power_ctrl & ~WM_POWER_CTRL) == RST_POWER_CTRL && state_reg.core_ctrl[15:8] == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits changed");

	property p_hold_off;
		state_reg.hold_time[6:0] == 7'h00 [*2] |-> !por_request_out;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("reset with timer disabled");

	property p_slow_gap;
		state_reg.slow_tick |=> !state_reg.slow_tick [*3];
	endproperty
	a_slow_gap: assert property (p_slow_gap) else $error("slow tick too frequent");

	property p_rail_manual;
		!state_reg.power_ctrl[PWR_AUTO_BIT] |=> rail_switch_closed_out == $past(state_reg.power_ctrl[PWR_RAIL_BIT]);
	endproperty
	a_rail_manual: assert property (p_rail_manual) else $error("manual rail switch wrong");

	property p_low_off;
		state_reg.power_ctrl[PWR_LOW_MODE_LSB +: 2] == 2'h1 |=> !low_regulator_on_out;
	endproperty
	a_low_off: assert property (p_low_off) else $error("low regulator not off");

	property p_xtal_mv;
		state_reg.level_trim[LVL_XTAL_LSB +: 3] == 3'h3 [*2] |-> crystal_regulator_mv_out == XTAL_NOM_MV;
	endproperty
	a_xtal_mv: assert property (p_xtal_mv) else $error("crystal regulator target wrong");
endmodule
`default_nettype wire

/* File: verification/cpcr_regs_tb_top.sv */
/*
 Self-checking bench for the clock and power control register bank.
 Assumes the design takes shortened slow-tick, hold and refresh counts through its parameters.
*/
`default_nettype none
module cpcr_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import cpcr_pkg::*;
	localparam int SD = 4;
	localparam int HT = 4;
	localparam int RU = 8;
	logic ref_clk_in = 0;
	logic srst_in = 1;
	logic [31:0] addr_in = '0;
	logic [15:0] wdata_in = '0;
	logic [11:0] gpio_in = '0;
	logic wr_in = 0, rd_in = 0, xtal_enable_in = 0, sleep_in = 0, boost_mode_in = 0, vbat_high_ok_in = 0;
	logic reset_pad_n_in = 1;
	logic [15:0] rdata_out;
	logic [11:0] dcdc_target_mv_out, crystal_regulator_mv_out, low_regulator_mv_out;
	logic [7:0] crystal_start_code_out, crystal_ramp_code_out;
	logic [2:0] core_ampl_trim_out, core_current_out;
	logic por_vbat_high_off_out, por_vbat_low_off_out, cmp_high_ok_enable_out, cmp_high_nok_enable_out;
	logic irq_out, por_request_out, bandgap_refresh_out, amp_detector_bias_keep_out, dcblock_enable_out;
	logic rail_switch_closed_out, low_regulator_on_out, low_regulator_high_current_out;
	logic core_regulator_retention_out, core_regulator_off_out, charge_pump_off_out, reference_hold_force_out;
	logic [15:0] expq[$];
	logic rd_d = 0;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	int q;
	logic [15:0] v;
	logic [31:0] ra [8] = '{ADDR_START_TRIM, ADDR_READY_DELAY, ADDR_CORE_CTRL, ADDR_PIN_SELECT,
		ADDR_HOLD_TIME, ADDR_REFRESH, ADDR_POWER_CTRL, ADDR_LEVEL_TRIM};
	logic [15:0] rr [8] = '{RST_START_TRIM, RST_READY_DELAY, RST_CORE_CTRL, RST_PIN_SELECT,
		RST_HOLD_TIME, RST_REFRESH, RST_POWER_CTRL, RST_LEVEL_TRIM};
	logic [15:0] rm [8] = '{WM_START_TRIM, WM_READY_DELAY, WM_CORE_CTRL, WM_PIN_SELECT,
		WM_HOLD_TIME, WM_REFRESH, WM_POWER_CTRL, WM_LEVEL_TRIM};
	logic [11:0] nom [4] = '{DCDC_1V1_MV, DCDC_1V8_MV, DCDC_2V5_MV, DCDC_3V0_MV};

	cpcr_regs #(.SLOW_DIV(SD), .HOLD_TICKS(HT), .REFRESH_UNIT(RU)) dut_u (
		.ref_clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.xtal_enable_in, .sleep_in, .boost_mode_in, .vbat_high_ok_in, .reset_pad_n_in, .gpio_in,
		.irq_out, .por_request_out, .bandgap_refresh_out, .crystal_start_code_out,
		.crystal_ramp_code_out, .core_ampl_trim_out, .core_current_out,
		.amp_detector_bias_keep_out, .dcblock_enable_out, .rail_switch_closed_out,
		.low_regulator_on_out, .low_regulator_high_current_out, .core_regulator_retention_out,
		.core_regulator_off_out, .charge_pump_off_out, .reference_hold_force_out,
		.por_vbat_high_off_out, .por_vbat_low_off_out, .cmp_high_ok_enable_out,
		.cmp_high_nok_enable_out, .dcdc_target_mv_out, .crystal_regulator_mv_out, .low_regulator_mv_out);

	always #25 ref_clk_in = ~ref_clk_in;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge ref_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1;
		rd_in <= 0;
	endtask

	// Read data is judged by the monitor one cycle later
	task automatic rd(input logic [31:0] a, input logic [15:0] e);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in <= 1;
		wr_in <= 0;
		expq.push_back(e);
	endtask

	task automatic settle(input int k);
		repeat (k) begin
			@(posedge ref_clk_in);
			wr_in <= 0;
			rd_in <= 0;
		end
		#1;
	endtask

	// Edges until irq (0), por (1) or refresh pulse (2) is seen, capped at lim
	task automatic waitfor(input int w, input int lim, output int k);
		k = 0;
		do begin
			@(posedge ref_clk_in);
			k++;
		end while (k < lim && (w == 0 ? irq_out : w == 1 ? por_request_out : bandgap_refresh_out) !== 1'b1);
	endtask

	always @(posedge ref_clk_in) begin
		if (rd_d)
			chk(rdata_out, expq.pop_front());
		rd_d <= rd_in;
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("Error at %0t: timeout", $time);
			print_verdict();
		end
	end

	initial begin
		void'($urandom(32'h1023));
		repeat (16) @(posedge ref_clk_in);
		srst_in <= 0;
		for (int i = 0; i < 8; i++) rd(ra[i], rr[i]);
		rd(ADDR_IRQ_STATUS, 16'h0000);
		rd(32'h5000_0044, 16'h0000);
		settle(2);
		chk(crystal_start_code_out, 8'haa);
		chk(dcblock_enable_out, 1);
		chk(dcdc_target_mv_out, DCDC_1V8_MV);
		chk(crystal_regulator_mv_out, XTAL_NOM_MV);
		chk(low_regulator_mv_out, LOW_NOM_MV + 4 * STEP_MV);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			v = 16'($urandom);
			wr(ra[i], v);
			rd(ra[i], (v & rm[i]) | (rr[i] & ~rm[i]));
		end
		wr(32'h5000_0044, 16'hffff);
		rd(32'h5000_0044, 16'h0000);
		wr(ADDR_HOLD_TIME, 16'h0000);
		wr(ADDR_START_TRIM, 16'h1234);
		wr(ADDR_CORE_CTRL, 16'h00b2);
		settle(3);
		chk(crystal_start_code_out, 8'h34);
		chk(crystal_ramp_code_out, 8'h12);
		chk(amp_detector_bias_keep_out, 1);
		chk(dcblock_enable_out, 0);
		chk({core_ampl_trim_out, core_current_out}, 6'h2c);
		wr(ADDR_CORE_CTRL, 16'h0001);
		settle(3);
		chk(amp_detector_bias_keep_out, 0);
		chk(dcblock_enable_out, 1);
		$display("test readback done");
		wr(ADDR_POWER_CTRL, 16'h0194);
		settle(3);
		chk(charge_pump_off_out, 1);
		chk(core_regulator_off_out, 1);
		chk(reference_hold_force_out, 1);
		chk(core_regulator_retention_out, 0);
		chk(rail_switch_closed_out, 1);
		chk({por_vbat_high_off_out, por_vbat_low_off_out, cmp_high_ok_enable_out, cmp_high_nok_enable_out}, 0);
		wr(ADDR_POWER_CTRL, 16'h120b);
		settle(3);
		chk(charge_pump_off_out, 0);
		chk(core_regulator_off_out, 0);
		chk(reference_hold_force_out, 0);
		chk(core_regulator_retention_out, 1);
		chk(rail_switch_closed_out, 0);
		chk({por_vbat_high_off_out, por_vbat_low_off_out, cmp_high_ok_enable_out, cmp_high_nok_enable_out}, 4'hf);
		wr(ADDR_POWER_CTRL, 16'h8000);
		boost_mode_in <= 1;
		vbat_high_ok_in <= 1;
		settle(5);
		chk(rail_switch_closed_out, 1);
		@(posedge ref_clk_in);
		vbat_high_ok_in <= 0;
		settle(5);
		chk(rail_switch_closed_out, 0);
		for (int m = 0; m < 8; m++) begin
			q = m >> 1;
			wr(ADDR_POWER_CTRL, 16'(q) << 5);
			sleep_in <= m[0];
			settle(3);
			chk(low_regulator_on_out, q != 1 && !(q == 0 && m[0]));
			chk(low_regulator_high_current_out, (q == 0 || q == 3) && !m[0]);
		end
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_LEVEL_TRIM, 16'(c << 11 | (c % 4) << 9 | c << 4 | c << 1));
			settle(3);
			chk(dcdc_target_mv_out, nom[c % 4] + 12'(c) * STEP_MV - TRIM_ZERO_MV);
			chk(crystal_regulator_mv_out, XTAL_NOM_MV + 12'(c) * STEP_MV - TRIM_ZERO_MV);
			chk(low_regulator_mv_out, LOW_NOM_MV + 12'(c) * STEP_MV - TRIM_ZERO_MV);
		end
		$display("test power outputs done");
		wr(ADDR_IRQ_STATUS, 16'h0003);
		wr(ADDR_IRQ_MASK, 16'h0001);
		wr(ADDR_READY_DELAY, 16'h0003);
		settle(2);
		@(posedge ref_clk_in);
		xtal_enable_in <= 1;
		waitfor(0, 100, n);
		chk(n >= 2 * SD && n <= 3 * SD + 4, 1);
		rd(ADDR_IRQ_STATUS, 16'h0001);
		wr(ADDR_IRQ_STATUS, 16'h0001);
		wr(ADDR_READY_DELAY, 16'h0000);
		xtal_enable_in <= 0;
		settle(3);
		chk(irq_out, 0);
		@(posedge ref_clk_in);
		xtal_enable_in <= 1;
		waitfor(0, 40, n);
		chk(irq_out, 0);
		wr(ADDR_READY_DELAY, 16'h0002);
		wr(ADDR_IRQ_MASK, 16'h0000);
		xtal_enable_in <= 0;
		settle(2);
		@(posedge ref_clk_in);
		xtal_enable_in <= 1;
		waitfor(0, 30, n);
		chk(irq_out, 0);
		rd(ADDR_IRQ_STATUS, 16'h0001);
		wr(ADDR_IRQ_MASK, 16'h0001);
		settle(3);
		chk(irq_out, 1);
		wr(ADDR_IRQ_STATUS, 16'h0001);
		settle(3);
		chk(irq_out, 0);
		$display("test crystal ready done");
		wr(ADDR_PIN_SELECT, 16'h008c);
		wr(ADDR_HOLD_TIME, 16'h0002);
		settle(2);
		@(posedge ref_clk_in);
		gpio_in <= 12'h800;
		waitfor(1, 100, n);
		chk(n >= 2 * HT * SD - SD && n <= 2 * HT * SD + SD + 6, 1);
		@(posedge ref_clk_in);
		gpio_in <= 12'h000;
		settle(5);
		chk(por_request_out, 0);
		wr(ADDR_PIN_SELECT, 16'h0001);
		waitfor(1, 100, n);
		chk(por_request_out, 1);
		@(posedge ref_clk_in);
		gpio_in <= 12'hfff;
		settle(5);
		chk(por_request_out, 0);
		wr(ADDR_PIN_SELECT, 16'h0000);
		reset_pad_n_in <= 0;
		waitfor(1, 100, n);
		chk(por_request_out, 1);
		@(posedge ref_clk_in);
		reset_pad_n_in <= 1;
		settle(5);
		chk(por_request_out, 0);
		for (int c = 0; c < 16; c++) if (c == 0 || c > 12) begin
			wr(ADDR_PIN_SELECT, 16'(c | 8'h80));
			waitfor(1, 60, n);
			chk(por_request_out, 0);
		end
		wr(ADDR_HOLD_TIME, 16'h0000);
		wr(ADDR_PIN_SELECT, 16'h0081);
		waitfor(1, 60, n);
		chk(por_request_out, 0);
		$display("test pin reset done");
		wr(ADDR_REFRESH, 16'h0002);
		settle(1);
		repeat (3) waitfor(2, 100, n);
		chk(n, 2 * RU);
		wr(ADDR_REFRESH, 16'h0000);
		settle(2);
		waitfor(2, 40, n);
		chk(n, 40);
		$display("test refresh done");
		print_verdict();
	end
endmodule
`default_nettype wire
